/* rtl/exec_pkg.sv */
package exec_pkg;
   localparam int DATA_W = 8;
   localparam int ROM_W = 16;
   localparam int ADDR_W = 8;
   localparam int PC_W = 13;
   localparam int PAGE_W = 8;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] THB_RESET = 8'h00;
   localparam logic [7:0] ALL_ONES = 8'hFF;
   localparam logic [3:0] FLAG_RESET = 4'h0;
   localparam int FLAG_C = 0;
   localparam int FLAG_H = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_V = 3;
   localparam int SKIP_CYCLES = 2;

   typedef enum logic [4:0] {
      OP_NOP = 5'h00,
      OP_ROT_ACC = 5'h01,
      OP_ROT_MEM = 5'h02,
      OP_SUBB = 5'h03,
      OP_SUBB_MEM = 5'h04,
      OP_SUB = 5'h05,
      OP_SUB_MEM = 5'h06,
      OP_SUBI = 5'h07,
      OP_DEC_SKIP = 5'h08,
      OP_DEC_SKIP_ACC = 5'h09,
      OP_INC_SKIP = 5'h0A,
      OP_INC_SKIP_ACC = 5'h0B,
      OP_SNZB = 5'h0C,
      OP_ZERO_SKIP = 5'h0D,
      OP_SZB = 5'h0E,
      OP_MOVE_SKIP = 5'h0F,
      OP_SET = 5'h10,
      OP_SETB = 5'h11,
      OP_SWAP = 5'h12,
      OP_SWAP_ACC = 5'h13,
      OP_TABC = 5'h14,
      OP_TABL = 5'h15,
      OP_XOR = 5'h16,
      OP_XORI = 5'h17,
      OP_XOR_MEM = 5'h18
   } op_e;

   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_DUMMY = 2'b10
   } phase_e;
endpackage

/* rtl/sub_adder.sv */
`timescale 1ns/1ns
`default_nettype none
// a + b + cin with carry, nibble carry and signed overflow
module sub_adder #(
   parameter int W = 8
) (
   input wire logic [W-1:0] a, // first operand
   input wire logic [W-1:0] b, // second operand, already inverted
   input wire logic cin, // carry in
   output logic [W-1:0] sum, // result
   output logic cout, // carry out (no borrow)
   output logic hcout, // carry out of low nibble
   output logic ovf // signed overflow
);
   logic [W:0] full;
   logic [4:0] low;
   always_comb begin
      full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
      low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      sum = full[W-1:0];
      cout = full[W];
      hcout = low[4];
      ovf = (a[W-1] == b[W-1]) && (sum[W-1] != a[W-1]);
   end
endmodule
`default_nettype wire

/* rtl/exec_unit.sv */
// Local design decision: the address-and-strobe write port.
`timescale 1ns/1ns
`default_nettype none
module exec_unit
   import exec_pkg::*;
#(
   parameter int PCW = PC_W
) (
   input wire logic clk, // system clock
   input wire logic rst, // async reset, active high
   input wire logic issue, // instruction valid this cycle
   input wire exec_pkg::op_e op, // decoded operation
   input wire logic [exec_pkg::ADDR_W-1:0] mem_addr, // operand address
   input wire logic [2:0] bit_sel, // selected bit
   input wire logic [7:0] imm, // immediate value
   input wire logic [7:0] mem_rdata, // operand read from data memory
   input wire logic [7:0] table_pointer, // table pointer register
   input wire logic [PCW-1:0] pc, // current program counter
   input wire logic [15:0] rom_rdata, // program word, same cycle
   output logic [PCW-1:0] rom_addr, // program word address
   output logic [exec_pkg::ADDR_W-1:0] mem_waddr, // write address
   output logic [7:0] mem_wdata, // write data
   output logic mem_we, // write strobe
   output logic [7:0] acc, // accumulator
   output logic [7:0] table_high_byte, // latched table high byte
   output logic main_borrow_bit, // carry / not borrow
   output logic nibble_carry_bit, // half carry
   output logic null_result_bit, // zero flag
   output logic signed_excess_bit, // overflow flag
   output logic flush, // discard fetched instruction
   output logic busy // dummy cycle in progress
);
   import exec_pkg::*;

   logic [7:0] acc_q, acc_d;
   logic [7:0] thb_q, thb_d;
   logic [3:0] flags_q, flags_d;
   logic [7:0] wdata_q, wdata_d;
   logic [ADDR_W-1:0] waddr_q, waddr_d;
   logic we_q, we_d;
   logic flush_q, flush_d;
   phase_e phase_q, phase_d;

   logic [7:0] add_b;
   logic add_cin;
   logic [7:0] add_sum;
   logic add_c, add_h, add_v;
   logic [7:0] dec_v, inc_v, res;
   logic [7:0] bit_mask;
   logic is_sub, skip, to_mem, to_acc, set_z;

   sub_adder #(.W(DATA_W)) u_add (
      .a(acc_q),
      .b(add_b),
      .cin(add_cin),
      .sum(add_sum),
      .cout(add_c),
      .hcout(add_h),
      .ovf(add_v)
   );

   // operand selection for the subtractor
   always_comb begin
      add_b = ~mem_rdata;
      add_cin = 1'b1;
      is_sub = 1'b0;
      unique case (op)
         OP_SUBB, OP_SUBB_MEM: begin
            add_cin = flags_q[FLAG_C];
            is_sub = 1'b1;
         end
         OP_SUB, OP_SUB_MEM: is_sub = 1'b1;
         OP_SUBI: begin
            add_b = ~imm;
            is_sub = 1'b1;
         end
         default: ;
      endcase
   end

   always_comb begin
      dec_v = mem_rdata - 8'h01;
      inc_v = mem_rdata + 8'h01;
      bit_mask = 8'h01 << bit_sel;
      // table word from current page or last page
      if (op == OP_TABL) begin
         rom_addr = {{(PCW-PAGE_W){1'b1}}, table_pointer};
      end else begin
         rom_addr = {pc[PCW-1:PAGE_W], table_pointer};
      end
   end

   // execute: next accumulator, flags, memory write and skip
   always_comb begin
      acc_d = acc_q;
      thb_d = thb_q;
      flags_d = flags_q;
      wdata_d = wdata_q;
      waddr_d = waddr_q;
      we_d = 1'b0;
      flush_d = 1'b0;
      phase_d = ST_RUN;
      res = 8'h00;
      skip = 1'b0;
      to_mem = 1'b0;
      to_acc = 1'b0;
      set_z = 1'b0;
      if (phase_q == ST_DUMMY) begin
         phase_d = ST_RUN;
      end else if (issue) begin
         unique case (op)
            OP_ROT_ACC, OP_ROT_MEM: begin
               res = {flags_q[FLAG_C], mem_rdata[7:1]};
               flags_d[FLAG_C] = mem_rdata[0];
               to_acc = (op == OP_ROT_ACC);
               to_mem = (op == OP_ROT_MEM);
            end
            OP_SUBB, OP_SUBB_MEM, OP_SUB, OP_SUB_MEM, OP_SUBI: begin
               res = add_sum;
               flags_d[FLAG_C] = add_c;
               flags_d[FLAG_H] = add_h;
               flags_d[FLAG_V] = add_v;
               set_z = 1'b1;
               to_mem = (op == OP_SUBB_MEM) || (op == OP_SUB_MEM);
               to_acc = !to_mem;
            end
            OP_DEC_SKIP, OP_DEC_SKIP_ACC: begin
               res = dec_v;
               skip = (dec_v == 8'h00);
               to_mem = (op == OP_DEC_SKIP);
               to_acc = (op == OP_DEC_SKIP_ACC);
            end
            OP_INC_SKIP, OP_INC_SKIP_ACC: begin
               res = inc_v;
               skip = (inc_v == 8'h00);
               to_mem = (op == OP_INC_SKIP);
               to_acc = (op == OP_INC_SKIP_ACC);
            end
            OP_SNZB: skip = |(mem_rdata & bit_mask);
            OP_ZERO_SKIP: skip = (mem_rdata == 8'h00);
            OP_SZB: skip = ~|(mem_rdata & bit_mask);
            OP_MOVE_SKIP: begin
               res = mem_rdata;
               to_acc = 1'b1;
               skip = (mem_rdata == 8'h00);
            end
            OP_SET: begin
               res = ALL_ONES;
               to_mem = 1'b1;
            end
            OP_SETB: begin
               res = mem_rdata | bit_mask;
               to_mem = 1'b1;
            end
            OP_SWAP, OP_SWAP_ACC: begin
               res = {mem_rdata[3:0], mem_rdata[7:4]};
               to_mem = (op == OP_SWAP);
               to_acc = (op == OP_SWAP_ACC);
            end
            OP_TABC, OP_TABL: begin
               res = rom_rdata[7:0];
               thb_d = rom_rdata[15:8];
               to_mem = 1'b1;
            end
            OP_XOR: begin
               res = acc_q ^ mem_rdata;
               to_acc = 1'b1;
               set_z = 1'b1;
            end
            OP_XORI: begin
               res = acc_q ^ imm;
               to_acc = 1'b1;
               set_z = 1'b1;
            end
            OP_XOR_MEM: begin
               res = acc_q ^ mem_rdata;
               to_mem = 1'b1;
               set_z = 1'b1;
            end
            default: ;
         endcase
         if (set_z) begin
            flags_d[FLAG_Z] = (res == 8'h00);
         end
         if (to_acc) begin
            acc_d = res;
         end
         if (to_mem) begin
            we_d = 1'b1;
            wdata_d = res;
            waddr_d = mem_addr;
         end
         if (skip) begin
            flush_d = 1'b1;
            phase_d = ST_DUMMY;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_q <= ACC_RESET;
         thb_q <= THB_RESET;
         flags_q <= FLAG_RESET;
         wdata_q <= 8'h00;
         waddr_q <= '0;
         we_q <= 1'b0;
         flush_q <= 1'b0;
         phase_q <= ST_RUN;
      end else begin
         acc_q <= acc_d;
         thb_q <= thb_d;
         flags_q <= flags_d;
         wdata_q <= wdata_d;
         waddr_q <= waddr_d;
         we_q <= we_d;
         flush_q <= flush_d;
         phase_q <= phase_d;
      end
   end

   always_comb begin
      acc = acc_q;
      table_high_byte = thb_q;
      main_borrow_bit = flags_q[FLAG_C];
      nibble_carry_bit = flags_q[FLAG_H];
      null_result_bit = flags_q[FLAG_Z];
      signed_excess_bit = flags_q[FLAG_V];
      mem_wdata = wdata_q;
      mem_waddr = waddr_q;
      mem_we = we_q;
      flush = flush_q;
      busy = (phase_q == ST_DUMMY);
   end
endmodule
`default_nettype wire

/* bench/exec_unit_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module exec_unit_sva
   import exec_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic rst, // async reset
   input wire logic issue, // op valid
   input wire exec_pkg::op_e op, // operation
   input wire logic [exec_pkg::ADDR_W-1:0] mem_addr, // operand address
   input wire logic [7:0] mem_rdata, // operand
   input wire logic [15:0] rom_rdata, // program word
   input wire logic [exec_pkg::ADDR_W-1:0] mem_waddr, // write address
   input wire logic [7:0] mem_wdata, // write data
   input wire logic mem_we, // write strobe
   input wire logic [7:0] acc, // accumulator
   input wire logic [7:0] table_high_byte, // table high byte
   input wire logic main_borrow_bit, // carry
   input wire logic nibble_carry_bit, // half carry
   input wire logic null_result_bit, // zero
   input wire logic signed_excess_bit, // overflow
   input wire logic flush, // discard pulse
   input wire logic busy // dummy cycle
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic go;
   logic [3:0] fl;
   assign go = issue && !busy;
   assign fl = {signed_excess_bit, null_result_bit, nibble_carry_bit,
      main_borrow_bit};
   sequence s_dummy;
      flush && busy ##1 !flush && !busy;
   endsequence
   property p_sz_skip;
      go && op == OP_ZERO_SKIP && mem_rdata == 8'h00 |=> s_dummy;
   endproperty
   property p_no_skip;
      go && op == OP_ZERO_SKIP && mem_rdata != 8'h00 |=> !flush && !busy;
   endproperty
   property p_refuse;
      busy |=> !busy && !mem_we && !flush;
   endproperty
   property p_set;
      go && op == OP_SET |=> mem_we && mem_wdata == 8'hFF &&
         mem_waddr == $past(mem_addr);
   endproperty
   property p_exclusive_or_to_memory;
      go && op == OP_XOR_MEM |=> mem_we &&
         mem_wdata == ($past(acc) ^ $past(mem_rdata)) &&
         null_result_bit == (mem_wdata == 8'h00);
   endproperty
   property p_rotate_right_thru_borrow_to_acc;
      go && op == OP_ROT_ACC |=> main_borrow_bit == $past(mem_rdata[0]) &&
         acc == {$past(main_borrow_bit), $past(mem_rdata[7:1])};
   endproperty
   property p_sdz_flags;
      go && op == OP_DEC_SKIP |=> $stable(fl);
   endproperty
   property p_tab;
      go && op == OP_TABC |=> table_high_byte == $past(rom_rdata[15:8])
         && mem_wdata == $past(rom_rdata[7:0]);
   endproperty
   property p_nibble_exchange_to_acc;
      go && op == OP_SWAP_ACC |=> !mem_we &&
         acc == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])};
   endproperty
   a_sz_skip: assert property (p_sz_skip)
      else $error("zero test skip wrong");
   a_no_skip: assert property (p_no_skip)
      else $error("skip without cause");
   a_refuse: assert property (p_refuse)
      else $error("dummy cycle not single or issue taken");
   a_set: assert property (p_set)
      else $error("byte set wrong");
   a_exclusive_or_to_memory: assert property (p_exclusive_or_to_memory)
      else $error("xor to memory wrong");
   a_rotate_right_thru_borrow_to_acc: assert property (p_rotate_right_thru_borrow_to_acc)
      else $error("rotate to acc wrong");
   a_sdz_flags: assert property (p_sdz_flags)
      else $error("decrement skip changed flags");
   a_tab: assert property (p_tab)
      else $error("table read wrong");
   a_nibble_exchange_to_acc: assert property (p_nibble_exchange_to_acc)
      else $error("swap to acc wrong");
endmodule
`default_nettype wire

/* bench/exec_unit_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module exec_unit_tb;
   import exec_pkg::*;
   logic clk = 0, rst = 1, issue = 0;
   op_e op = OP_NOP;
   logic [7:0] mem_addr = 8'h33, imm = 8'h00, mem_rdata = 8'h00;
   logic [7:0] table_pointer = 8'h44, mem_waddr, mem_wdata, acc;
   logic [7:0] table_high_byte;
   logic [2:0] bit_sel = 3'h0;
   logic [12:0] pc = 13'h0234, rom_addr, ra;
   logic [15:0] rom_rdata = 16'hBEEF;
   logic mem_we, main_borrow_bit, nibble_carry_bit, null_result_bit;
   logic signed_excess_bit, flush, busy;
   logic [3:0] fl;
   int error_cnt = 0, n_checks = 0, cyc = 0;
   assign fl = {signed_excess_bit, null_result_bit, nibble_carry_bit,
      main_borrow_bit};
   exec_unit dut (.clk(clk), .rst(rst), .issue(issue), .op(op),
      .mem_addr(mem_addr), .bit_sel(bit_sel), .imm(imm),
      .mem_rdata(mem_rdata), .table_pointer(table_pointer), .pc(pc),
      .rom_rdata(rom_rdata), .rom_addr(rom_addr), .mem_waddr(mem_waddr),
      .mem_wdata(mem_wdata), .mem_we(mem_we), .acc(acc),
      .table_high_byte(table_high_byte), .main_borrow_bit(main_borrow_bit),
      .nibble_carry_bit(nibble_carry_bit), .null_result_bit(null_result_bit),
      .signed_excess_bit(signed_excess_bit), .flush(flush), .busy(busy));
   initial forever #10 clk = ~clk;
   task automatic results;
      if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one issue, sampled mid-cycle after the answering edge
   task automatic run(input op_e o, input logic [7:0] m,
         input logic [2:0] b = 3'h0, input logic [7:0] i = 8'h00);
      @(posedge clk);
      issue <= 1'b1;
      op <= o;
      mem_rdata <= m;
      bit_sel <= b;
      imm <= i;
      @(negedge clk);
      ra = rom_addr;
      @(posedge clk);
      issue <= 1'b0;
      @(negedge clk);
   endtask
   task automatic sk(input op_e o, input logic [7:0] m, input logic [2:0] b,
         input logic f);
      run(o, m, b);
      chk(flush, f);
      chk(busy, f);
      chk(fl, 4'h1);
   endtask
   task automatic t_rot;
      run(OP_ROT_MEM, 8'h01);
      chk(mem_wdata, 8'h00);
      chk(main_borrow_bit, 1'b1);
      run(OP_ROT_ACC, 8'h80);
      chk(acc, 8'hC0);
      chk(main_borrow_bit, 1'b0);
      chk(mem_we, 1'b0);
      run(OP_ROT_MEM, 8'h03);
      chk(mem_wdata, 8'h01);
   endtask
   task automatic t_skip;
      run(OP_SWAP_ACC, 8'h01);
      run(OP_SUB, 8'h01);
      chk(acc, 8'h0F);
      chk(fl, 4'h1);
      sk(OP_DEC_SKIP, 8'h01, 3'h0, 1'b1);
      chk(mem_wdata, 8'h00);
      sk(OP_DEC_SKIP_ACC, 8'h02, 3'h0, 1'b0);
      chk(acc, 8'h01);
      chk(mem_we, 1'b0);
      sk(OP_INC_SKIP, 8'hFF, 3'h0, 1'b1);
      chk(mem_wdata, 8'h00);
      sk(OP_INC_SKIP_ACC, 8'h07, 3'h0, 1'b0);
      chk(acc, 8'h08);
      sk(OP_SNZB, 8'h10, 3'h4, 1'b1);
      sk(OP_SNZB, 8'hEF, 3'h4, 1'b0);
      sk(OP_ZERO_SKIP, 8'h00, 3'h0, 1'b1);
      sk(OP_ZERO_SKIP, 8'h80, 3'h0, 1'b0);
      sk(OP_SZB, 8'hF7, 3'h3, 1'b1);
      sk(OP_SZB, 8'h08, 3'h3, 1'b0);
      sk(OP_MOVE_SKIP, 8'h00, 3'h0, 1'b1);
      chk(acc, 8'h00);
   endtask
   task automatic t_refuse;
      @(posedge clk);
      issue <= 1'b1;
      op <= OP_ZERO_SKIP;
      mem_rdata <= 8'h00;
      @(posedge clk);
      op <= OP_SET;
      @(posedge clk);
      issue <= 1'b0;
      @(negedge clk);
      chk(mem_we, 1'b0);
      chk(busy, 1'b0);
   endtask
   task automatic t_sub;
      run(OP_SWAP_ACC, 8'hF0);
      run(OP_SUBB, 8'h0F);
      chk({acc, 4'h0, fl}, 16'h0007);
      run(OP_SUBI, 8'h00, 3'h0, 8'h80);
      chk({acc, 4'h0, fl}, 16'h800A);
      run(OP_SUBB_MEM, 8'h01);
      chk({mem_wdata, 4'h0, fl}, 16'h7E09);
      chk(acc, 8'h80);
      run(OP_SUB_MEM, 8'h80);
      chk({mem_wdata, 4'h0, fl}, 16'h0007);
   endtask
   task automatic t_misc;
      run(OP_SET, 8'h12);
      chk({mem_wdata, mem_waddr}, 16'hFF33);
      run(OP_SETB, 8'h01, 3'h5);
      chk({mem_wdata, 4'h0, fl}, 16'h2107);
      run(OP_SWAP, 8'h3C);
      chk(mem_wdata, 8'hC3);
      run(OP_SWAP_ACC, 8'hA5);
      chk({acc, 7'h0, mem_we}, 16'h5A00);
      run(OP_TABC, 8'h00);
      chk(ra, 13'h0244);
      chk({table_high_byte, mem_wdata}, 16'hBEEF);
      @(posedge clk);
      rom_rdata <= 16'h1234;
      run(OP_TABL, 8'h00);
      chk(ra, 13'h1F44);
      chk({table_high_byte, mem_wdata}, 16'h1234);
      chk(fl, 4'h7);
   endtask
   task automatic t_xor;
      run(OP_XORI, 8'h00, 3'h0, 8'h0F);
      chk({acc, 4'h0, fl}, 16'h5503);
      run(OP_XOR, 8'h55);
      chk({acc, 4'h0, fl}, 16'h0007);
      run(OP_XOR_MEM, 8'hF0);
      chk({mem_wdata, 3'h0, mem_we, fl}, 16'hF013);
      chk(acc, 8'h00);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         error_cnt++;
         results;
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_rot;
      t_skip;
      t_refuse;
      t_sub;
      t_misc;
      t_xor;
      results;
   end
endmodule
bind exec_unit exec_unit_sva chk_i (.clk(clk), .rst(rst), .issue(issue),
   .op(op), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
   .rom_rdata(rom_rdata), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
   .mem_we(mem_we), .acc(acc), .table_high_byte(table_high_byte),
   .main_borrow_bit(main_borrow_bit), .nibble_carry_bit(nibble_carry_bit),
   .null_result_bit(null_result_bit), .signed_excess_bit(signed_excess_bit),
   .flush(flush), .busy(busy));
`default_nettype wire
